// ==== test/tb_serial_channel_uart_mode_ctrl.sv ====
// bench for the serial channel mode block
// assumes the remote model and bound checker
`timescale 1ns/100ps
module tb_serial_channel_uart_mode_ctrl;
  logic        aclk, aresetn, ext_baud_clock_pin, rxd, got;       // clk, pins
  logic [15:0] s_axi_awaddr, s_axi_araddr;                        // addr
  logic [31:0] s_axi_wdata, s_axi_rdata, d;                       // data
  logic [3:0]  s_axi_wstrb;                                       // strobes
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;                       // resp
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready; // w
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready; // hs
  logic        s_axi_rvalid, s_axi_rready, txd_q, txd_oe_q;       // r, tx
  logic        rx_pin_used_q, clk_pin_used_q, rx_irq_q;           // pins
  logic [8:0]  v;                                                 // frame
  int          n_errors, checks;                                  // tallies
  serial_channel_uart_mode_ctrl dut (.*);
  uart_remote_model model (.aclk, .txd(txd_q), .rxd);
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  always @(posedge aclk) ext_baud_clock_pin <= ~ext_baud_clock_pin; // ext source
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] w);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= w;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rc(input logic [15:0] a, input logic [31:0] e);
    rd(a);
    chk("reg", e, d);
  endtask
  task automatic pins(input logic [2:0] e);
    repeat (2) @(posedge aclk);
    chk("pins", {29'h0, e}, {29'h0, txd_oe_q, rx_pin_used_q, clk_pin_used_q});
  endtask
  task automatic wirq(input int n);
    got = 1'b0;
    repeat (n) @(posedge aclk) if (rx_irq_q === 1'b1) got = 1'b1;
  endtask
  task automatic end_of_test;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic t_regs;
    rc(16'hff70, 32'h0);
    rc(16'hff72, 32'h0);
    rc(16'hff74, 32'h50);
    wr(16'hff74, 32'h0);
    rc(16'hff74, 32'h50);
    pins(3'b000);
    wr(16'hff72, 32'h86);
    rc(16'hff72, 32'h86);
    rc(16'hff80, 32'h20);
    wr(16'hff84, 32'h0f);
    rc(16'hff72, 32'h06);
    wr(16'hff84, 32'h17);
    rc(16'hff70, 32'h80);
    rd(16'hff90);
    chk("resp", 32'h2, {30'h0, r});
    wr(16'hff90, 32'h0);
    chk("bresp", 32'h2, {30'h0, r});
    wr(16'hff70, 32'h0);
    wr(16'hff72, 32'h0);
    rc(16'hff80, 32'h0);
  endtask
  task automatic t_tx;
    wr(16'hff74, 32'h1);
    for (int i = 0; i < 2; i++) begin
      wr(16'hff70, i ? 32'hc1 : 32'hc9);
      pins(3'b110);
      fork
        model.catch(v);
        wr(16'hff78, 32'h5a);
      join
      chk("frame", i ? 32'h1da : 32'h15a, {23'h0, v});
    end
  endtask
  task automatic t_rx;
    logic [9:0] tab [3] = '{10'h0d6, 10'h2d7, 10'h2d2};
    for (int i = 0; i < 3; i++) begin
      wr(16'hff70, {24'h0, tab[i][8:1]});
      pins(3'b010);
      fork
        model.send(8'h3c, 1'b1, tab[i][0], 1);
        wirq(250);
      join
      chk("irq", {31'h0, tab[i][9]}, {31'h0, got});
      rc(16'hff7c, 32'h3c);
    end
    wr(16'hff70, 32'h48);
    pins(3'b011);
    fork
      model.send(8'ha5, 1'b0, 1'b0, 2);
      wirq(500);
    join
    chk("irq", 32'h1, {31'h0, got});
    rc(16'hff7c, 32'ha5);
    wr(16'hff70, 32'h80);
    pins(3'b101);
    wr(16'hff70, 32'h0);
    pins(3'b000);
  endtask
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, ext_baud_clock_pin} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_tx;
    t_rx;
    end_of_test;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    end_of_test;
  end
endmodule

// ==== test/uart_mode_properties.sv ====
// port checker for the serial channel block
// assumes one clock, sync low reset; bound at foot
`timescale 1ns/100ps
module uart_mode_properties (
  input wire logic        aclk,          // clk
  input wire logic        aresetn,       // rst
  input wire logic        s_axi_arvalid, // ar
  input wire logic        s_axi_arready, // ar
  input wire logic        s_axi_rvalid,  // r
  input wire logic        s_axi_rready,  // r
  input wire logic [31:0] s_axi_rdata,   // r
  input wire logic        s_axi_bvalid,  // b
  input wire logic        s_axi_bready,  // b
  input wire logic        txd_q,         // tx
  input wire logic        txd_oe_q,      // tx on
  input wire logic        rx_pin_used_q, // rx on
  input wire logic        rx_irq_q       // rx done
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // start bit held low
  sequence s_start; !txd_q [*8]; endsequence
  chk_idle_high: assert property (!txd_oe_q |-> txd_q) else $error("idle");
  chk_start_low: assert property ($fell(txd_q) |-> s_start) else $error("start");
  chk_irq_rx_on: assert property (rx_irq_q |-> rx_pin_used_q) else $error("irq");
  chk_irq_pulse: assert property (rx_irq_q |=> !rx_irq_q) else $error("pulse");
  chk_ar_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("ar");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("r");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("b");
  chk_r_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0) else $error("u");
endmodule
bind serial_channel_uart_mode_ctrl uart_mode_properties chk (.*);

// ==== test/uart_remote_model.sv ====
// remote uart: sends frames on rxd, catches txd
// assumes one tick a clock, so 16 clocks a bit
`timescale 1ns/100ps
module uart_remote_model #(parameter int bit_cyc = 16) (
  input wire logic aclk, // clk
  input wire logic txd,  // from block
  output logic     rxd   // to block
);
  initial rxd = 1'b1; // idle high
  // start, data lsb first, parity or idle, one stop
  task automatic send(input logic [7:0] b, input logic pon, input logic p,
                      input int k); // k stretches each bit
    logic [10:0] f;
    f = {1'b1, pon ? p : 1'b1, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd <= f[i];
      repeat (bit_cyc * k) @(posedge aclk);
    end
  endtask
  // mid-bit capture of data and stop
  task automatic catch(output logic [8:0] v);
    @(negedge txd);
    repeat (bit_cyc / 2) @(posedge aclk);
    for (int i = 0; i < 9; i++) begin
      repeat (bit_cyc) @(posedge aclk);
      v[i] = txd;
    end
    repeat (bit_cyc) @(posedge aclk);
  endtask
endmodule

// ==== verilog/serial_channel_uart_mode_ctrl.sv ====
// serial channel mode control with uart framing, axi4-lite registers
// assumes aclk 40 mhz, synchronous pins, one outstanding access per channel
`timescale 1ns/100ps
module serial_channel_uart_mode_ctrl (
  input  wire logic        aclk,          // system clock
  input  wire logic        aresetn,       // sync reset, active low
  input  wire logic [15:0] s_axi_awaddr,  // write address
  input  wire logic        s_axi_awvalid, // write address valid
  output logic             s_axi_awready, // write address ready
  input  wire logic [31:0] s_axi_wdata,   // write data
  input  wire logic [3:0]  s_axi_wstrb,   // write strobes
  input  wire logic        s_axi_wvalid,  // write data valid
  output logic             s_axi_wready,  // write data ready
  output logic [1:0]       s_axi_bresp,   // write response
  output logic             s_axi_bvalid,  // write response valid
  input  wire logic        s_axi_bready,  // write response ready
  input  wire logic [15:0] s_axi_araddr,  // read address
  input  wire logic        s_axi_arvalid, // read address valid
  output logic             s_axi_arready, // read address ready
  output logic [31:0]      s_axi_rdata,   // read data
  output logic [1:0]       s_axi_rresp,   // read response
  output logic             s_axi_rvalid,  // read valid
  input  wire logic        s_axi_rready,  // read ready
  input  wire logic        rxd,           // serial receive pin
  input  wire logic        ext_baud_clock_pin, // external baud clock input
  output logic             txd_q,         // serial transmit pin
  output logic             txd_oe_q,      // transmit pin driven
  output logic             rx_pin_used_q, // receive pin owned by channel
  output logic             clk_pin_used_q, // clock pin owned by channel
  output logic             rx_irq_q       // reception-complete request pulse
);
  uart_cfg_if cfg ();     // link to engines
  logic [7:0]  am_q, am_d;     // async mode register
  logic [7:0]  sm_q, sm_d;     // serial mode register
  logic [15:0] bd_q, bd_d;     // baud divider
  logic [7:0]  rb_q, rb_d;     // receive buffer
  logic        full_q, full_d; // receive buffer holds data
  logic        ovr_q, ovr_d;   // overrun flag
  logic        pe_q, pe_d;     // parity error flag
  logic        fe_q, fe_d;     // framing error flag
  logic        go_q, go_d;     // transmit load pulse
  logic [7:0]  tb_q, tb_d;     // transmit byte
  logic [15:0] dv_q, dv_d;     // tick divider count
  logic        ek_q, ek_d;     // previous external clock level
  logic        tk_q, tk_d;     // tick
  logic        irq_d;          // next irq pulse
  logic        txo_d, oe_d, rxu_d, cku_d; // next pin outputs
  logic        aw_q, aw_d;     // address held
  logic        w_q, w_d;       // data held
  logic [15:0] wa_q, wa_d;     // held write address
  logic [31:0] wd_q, wd_d;     // held write data
  logic [3:0]  ws_q, ws_d;     // held strobes
  logic        bv_q, bv_d;     // bvalid
  logic [1:0]  br_q, br_d;     // bresp
  logic        rv_q, rv_d;     // rvalid
  logic [31:0] rd_q, rd_d;     // rdata
  logic [1:0]  rr_q, rr_d;     // rresp
  logic        do_wr;          // write commits this cycle
  logic        rd_buf;         // receive buffer read this cycle
  logic        mapped_w;       // write address mapped
  uart_mode_pkg::chan_mode_t mode; // current mode
  logic        txd_eng;        // engine line

  // decodes register addresses into the map
  function automatic logic is_mapped(input logic [15:0] a);
    is_mapped = (a == uart_mode_pkg::async_mode_addr) ||
                (a == uart_mode_pkg::serial_mode_addr) ||
                (a == uart_mode_pkg::baud_gen_addr) ||
                (a == uart_mode_pkg::tx_data_addr) ||
                (a == uart_mode_pkg::rx_data_addr) ||
                (a == uart_mode_pkg::status_addr) ||
                (a == uart_mode_pkg::bit_set_addr);
  endfunction

  // mode from the two enable groups
  always_comb begin
    if (sm_q[uart_mode_pkg::three_wire_bit]) begin
      mode = uart_mode_pkg::mode_three_wire;
    end else if (am_q[uart_mode_pkg::txe_bit] || am_q[uart_mode_pkg::rxe_bit]) begin
      mode = uart_mode_pkg::mode_uart;
    end else begin
      mode = uart_mode_pkg::mode_stop;
    end
  end

  // configuration to engines
  assign cfg.tx_en      = (mode == uart_mode_pkg::mode_uart) && am_q[uart_mode_pkg::txe_bit];
  assign cfg.rx_en      = (mode == uart_mode_pkg::mode_uart) && am_q[uart_mode_pkg::rxe_bit];
  assign cfg.par_sel    = am_q[uart_mode_pkg::ps_hi:uart_mode_pkg::ps_lo];
  assign cfg.eight_bits = am_q[uart_mode_pkg::cl_bit];
  assign cfg.two_stop   = am_q[uart_mode_pkg::sl_bit];
  assign cfg.tx_start   = go_q;
  assign cfg.tx_byte    = tb_q;
  assign cfg.tick       = tk_q;

  uart_tx_engine u_tx (
    .aclk    (aclk),
    .aresetn (aresetn),
    .cfg     (cfg.tx),
    .txd_q   (txd_eng)
  );
  uart_rx_engine u_rx (
    .aclk    (aclk),
    .aresetn (aresetn),
    .rxd     (rxd),
    .cfg     (cfg.rx)
  );

  // baud tick: system clock or external pin edges, divided by bd_q
  always_comb begin
    ek_d = ext_baud_clock_pin;
    tk_d = 1'b0;
    dv_d = dv_q;
    if (am_q[uart_mode_pkg::sck_bit] || (ext_baud_clock_pin && !ek_q)) begin
      if (dv_q >= bd_q - 16'h0001) begin // divider can reach midi rate
        dv_d = 16'h0000;
        tk_d = 1'b1;
      end else begin
        dv_d = dv_q + 16'h0001;
      end
    end
  end

  // pins released outside uart use
  always_comb begin
    txo_d = cfg.tx_en ? txd_eng : 1'b1;
    oe_d  = cfg.tx_en;
    rxu_d = cfg.rx_en;
    cku_d = (mode == uart_mode_pkg::mode_uart) && !am_q[uart_mode_pkg::sck_bit];
  end

  // axi write channel
  assign do_wr    = aw_q && w_q && !bv_q;
  assign mapped_w = is_mapped(wa_q);
  always_comb begin
    aw_d = aw_q;
    w_d  = w_q;
    wa_d = wa_q;
    wd_d = wd_q;
    ws_d = ws_q;
    bv_d = bv_q;
    br_d = br_q;
    if (s_axi_awvalid && !aw_q) begin
      aw_d = 1'b1;
      wa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_q) begin
      w_d  = 1'b1;
      wd_d = s_axi_wdata;
      ws_d = s_axi_wstrb;
    end
    if (do_wr) begin
      aw_d = 1'b0;
      w_d  = 1'b0;
      bv_d = 1'b1;
      br_d = mapped_w ? uart_mode_pkg::resp_okay : uart_mode_pkg::resp_slverr;
    end
    if (bv_q && s_axi_bready) begin
      bv_d = 1'b0;
    end
  end

  // axi read channel
  assign rd_buf = s_axi_arvalid && !rv_q && (s_axi_araddr == uart_mode_pkg::rx_data_addr);
  always_comb begin
    rv_d = rv_q;
    rd_d = rd_q;
    rr_d = rr_q;
    if (s_axi_arvalid && !rv_q) begin
      rv_d = 1'b1;
      rr_d = is_mapped(s_axi_araddr) ? uart_mode_pkg::resp_okay : uart_mode_pkg::resp_slverr;
      case (s_axi_araddr)
        uart_mode_pkg::async_mode_addr:  rd_d = {24'h000000, am_q};
        uart_mode_pkg::serial_mode_addr: rd_d = {24'h000000, sm_q};
        uart_mode_pkg::baud_gen_addr:    rd_d = {16'h0000, bd_q};
        uart_mode_pkg::rx_data_addr:     rd_d = {24'h000000, rb_q};
        uart_mode_pkg::status_addr:
          rd_d = {25'h0, cfg.tx_busy, mode, full_q, pe_q, fe_q, ovr_q};
        default:                         rd_d = 32'h00000000;
      endcase
    end else if (rv_q && s_axi_rready) begin
      rv_d = 1'b0;
    end
  end

  // register file, receive flags and irq
  always_comb begin
    am_d   = am_q;
    sm_d   = sm_q;
    bd_d   = bd_q;
    tb_d   = tb_q;
    go_d   = 1'b0;
    rb_d   = rb_q;
    full_d = full_q;
    ovr_d  = ovr_q;
    pe_d   = pe_q;
    fe_d   = fe_q;
    irq_d  = 1'b0;
    if (do_wr && ws_q[0]) begin
      case (wa_q)
        uart_mode_pkg::async_mode_addr:  am_d = wd_q[7:0]; // byte write
        uart_mode_pkg::serial_mode_addr: sm_d = wd_q[7:0] & uart_mode_pkg::serial_wmask;
        uart_mode_pkg::baud_gen_addr:    bd_d = (wd_q[15:0] == 16'h0000) ?
                                                uart_mode_pkg::midi_div : wd_q[15:0];
        uart_mode_pkg::tx_data_addr: begin
          tb_d = wd_q[7:0];
          go_d = !cfg.tx_busy;
        end
        uart_mode_pkg::bit_set_addr: begin // single bit: [3]=reg, [2:0]=bit, [4]=value
          if (wd_q[3]) begin
            sm_d[wd_q[2:0]] = wd_q[4];
            sm_d = sm_d & uart_mode_pkg::serial_wmask;
          end else begin
            am_d[wd_q[2:0]] = wd_q[4];
          end
        end
        default: ;
      endcase
    end
    if (rd_buf) begin
      full_d = 1'b0;
      ovr_d  = 1'b0; // buffer read clears overrun
    end
    if (cfg.rx_done) begin // set beats clear
      rb_d   = cfg.rx_byte;
      pe_d   = cfg.rx_perr;
      fe_d   = cfg.rx_ferr;
      if (full_q && !rd_buf) begin
        ovr_d = 1'b1;
      end
      full_d = 1'b1;
      irq_d  = !((cfg.rx_perr || cfg.rx_ferr || (full_q && !rd_buf)) &&
                 am_q[uart_mode_pkg::irm_bit]);
    end
  end

  // all registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      am_q <= uart_mode_pkg::mode_reset;
      sm_q <= uart_mode_pkg::mode_reset;
      bd_q <= uart_mode_pkg::baud_reset;
      tb_q <= 8'h00;
      go_q <= 1'b0;
      rb_q <= 8'h00;
      full_q <= 1'b0;
      ovr_q <= 1'b0;
      pe_q <= 1'b0;
      fe_q <= 1'b0;
      dv_q <= 16'h0000;
      ek_q <= 1'b0;
      tk_q <= 1'b0;
      aw_q <= 1'b0;
      w_q  <= 1'b0;
      wa_q <= 16'h0000;
      wd_q <= 32'h00000000;
      ws_q <= 4'h0;
      bv_q <= 1'b0;
      br_q <= uart_mode_pkg::resp_okay;
      rv_q <= 1'b0;
      rd_q <= 32'h00000000;
      rr_q <= uart_mode_pkg::resp_okay;
      txd_q <= 1'b1;
      txd_oe_q <= 1'b0;
      rx_pin_used_q <= 1'b0;
      clk_pin_used_q <= 1'b0;
      rx_irq_q <= 1'b0;
    end else begin
      am_q <= am_d;
      sm_q <= sm_d;
      bd_q <= bd_d;
      tb_q <= tb_d;
      go_q <= go_d;
      rb_q <= rb_d;
      full_q <= full_d;
      ovr_q <= ovr_d;
      pe_q <= pe_d;
      fe_q <= fe_d;
      dv_q <= dv_d;
      ek_q <= ek_d;
      tk_q <= tk_d;
      aw_q <= aw_d;
      w_q  <= w_d;
      wa_q <= wa_d;
      wd_q <= wd_d;
      ws_q <= ws_d;
      bv_q <= bv_d;
      br_q <= br_d;
      rv_q <= rv_d;
      rd_q <= rd_d;
      rr_q <= rr_d;
      txd_q <= txo_d;
      txd_oe_q <= oe_d;
      rx_pin_used_q <= rxu_d;
      clk_pin_used_q <= cku_d;
      rx_irq_q <= irq_d;
    end
  end

  // axi outputs from flops
  assign s_axi_awready = !aw_q;
  assign s_axi_wready  = !w_q;
  assign s_axi_bvalid  = bv_q;
  assign s_axi_bresp   = br_q;
  assign s_axi_arready = !rv_q;
  assign s_axi_rvalid  = rv_q;
  assign s_axi_rdata   = rd_q;
  assign s_axi_rresp   = rr_q;
endmodule

// ==== verilog/uart_cfg_if.sv ====
// framing configuration carried from the core to tx and rx engines
// assumes one clock; config driven by the core, results driven by the engines
`timescale 1ns/100ps
interface uart_cfg_if;
  logic       tick;        // 16x oversample tick
  logic       tx_en;       // transmit enabled in uart mode
  logic       rx_en;       // receive enabled in uart mode
  logic [1:0] par_sel;     // parity scheme
  logic       eight_bits;  // 8 data bits when high
  logic       two_stop;    // two stop bits on transmit
  logic       tx_start;    // one-cycle load request
  logic [7:0] tx_byte;     // byte to send
  logic       tx_busy;     // transmitter active
  logic       rx_done;     // one-cycle character received
  logic [7:0] rx_byte;     // received character
  logic       rx_perr;     // parity error
  logic       rx_ferr;     // framing error
  modport core (output tick, tx_en, rx_en, par_sel, eight_bits, two_stop, tx_start,
                tx_byte, input tx_busy, rx_done, rx_byte, rx_perr, rx_ferr);
  modport tx (input tick, tx_en, par_sel, eight_bits, two_stop, tx_start, tx_byte,
              output tx_busy);
  modport rx (input tick, rx_en, par_sel, eight_bits, output rx_done, rx_byte,
              rx_perr, rx_ferr);
endinterface

// ==== verilog/uart_mode_pkg.sv ====
// constants for the serial channel mode control and uart framing block
// assumes a single 40 mhz clock domain and an axi4-lite register port
package uart_mode_pkg;
  // register byte addresses
  localparam logic [15:0] async_mode_addr  = 16'hff70; // async mode register
  localparam logic [15:0] serial_mode_addr = 16'hff72; // serial mode register
  localparam logic [15:0] baud_gen_addr    = 16'hff74; // baud divider register
  localparam logic [15:0] tx_data_addr     = 16'hff78; // transmit data register
  localparam logic [15:0] rx_data_addr     = 16'hff7c; // receive buffer register
  localparam logic [15:0] status_addr      = 16'hff80; // status register
  localparam logic [15:0] bit_set_addr     = 16'hff84; // single-bit write port
  // reset values
  localparam logic [7:0]  mode_reset  = 8'h00; // both mode registers
  localparam logic [15:0] baud_reset  = 16'h0050; // 40 mhz / 500 kHz tick
  // async mode register fields
  localparam int unsigned txe_bit = 7;  // transmit enable
  localparam int unsigned rxe_bit = 6;  // receive enable
  localparam int unsigned ps_hi   = 5;  // parity select high
  localparam int unsigned ps_lo   = 4;  // parity select low
  localparam int unsigned cl_bit  = 3;  // character length
  localparam int unsigned sl_bit  = 2;  // stop length
  localparam int unsigned irm_bit = 1;  // error irq suppress
  localparam int unsigned sck_bit = 0;  // internal clock select
  // serial mode register fields
  localparam int unsigned three_wire_bit = 7; // three wire enable
  localparam logic [7:0]  serial_wmask   = 8'h86; // writable serial bits
  // parity encodings
  localparam logic [1:0] par_none = 2'h0; // no parity
  localparam logic [1:0] par_zero = 2'h1; // zero bit, no check
  localparam logic [1:0] par_odd  = 2'h2; // odd parity
  localparam logic [1:0] par_even = 2'h3; // even parity
  // timing: 16 ticks per bit
  localparam logic [3:0] os_last  = 4'hf; // last oversample tick
  localparam logic [3:0] os_mid   = 4'h7; // mid-bit sample tick
  localparam int unsigned midi_bps = 31250; // midi rate
  localparam int unsigned clk_hz   = 40000000; // system clock
  localparam logic [15:0] midi_div = 16'((clk_hz + 8 * midi_bps) / (16 * midi_bps));
  // axi responses
  localparam logic [1:0] resp_okay   = 2'h0; // okay
  localparam logic [1:0] resp_slverr = 2'h2; // unmapped
  // mode enumeration
  typedef enum logic [1:0] {mode_stop, mode_uart, mode_three_wire} chan_mode_t;
  // framing helper: parity over the active data bits
  function automatic logic calc_par(input logic [7:0] d, input logic eight,
                                    input logic [1:0] sel);
    logic p;
    p = ^d[6:0] ^ (eight & d[7]);
    case (sel)
      par_odd:  calc_par = ~p;
      par_even: calc_par = p;
      default:  calc_par = 1'b0;
    endcase
  endfunction
endpackage

// ==== verilog/uart_rx_engine.sv ====
// receive sampler: mid-bit sampling, parity and single stop check
// assumes rxd is synchronous to aclk
`timescale 1ns/100ps
module uart_rx_engine (
  input  wire logic aclk,    // system clock
  input  wire logic aresetn, // sync reset, active low
  input  wire logic rxd,     // serial input
  uart_cfg_if.rx    cfg      // config and results
);
  typedef enum {sr_idle, sr_start, sr_data, sr_par, sr_stop} rx_state_t;
  rx_state_t  st_q, st_d;    // state
  logic [3:0] os_q, os_d;    // oversample count
  logic [3:0] n_q, n_d;      // bit count
  logic [7:0] sh_q, sh_d;    // shifter
  logic       pe_q, pe_d;    // parity error
  logic       fe_q, fe_d;    // framing error
  logic       dn_q, dn_d;    // done pulse
  assign cfg.rx_done = dn_q;
  assign cfg.rx_byte = sh_q;
  assign cfg.rx_perr = pe_q;
  assign cfg.rx_ferr = fe_q;
  // next-state logic
  always_comb begin
    st_d = st_q;
    os_d = os_q;
    n_d  = n_q;
    sh_d = sh_q;
    pe_d = pe_q;
    fe_d = fe_q;
    dn_d = 1'b0;
    if (!cfg.rx_en) begin
      st_d = sr_idle;
    end else if (cfg.tick) begin
      os_d = os_q + 4'h1;
      case (st_q)
        sr_idle: begin
          os_d = 4'h0;
          if (!rxd) begin // start edge
            st_d = sr_start;
          end
        end
        sr_start: if (os_q == uart_mode_pkg::os_mid) begin
          os_d = 4'h0;
          n_d  = 4'h0;
          sh_d = 8'h00;
          st_d = rxd ? sr_idle : sr_data;
        end
        sr_data: if (os_q == uart_mode_pkg::os_last) begin
          n_d = n_q + 4'h1;
          if (cfg.eight_bits) begin
            sh_d = {rxd, sh_q[7:1]};
          end else begin
            sh_d = {1'b0, rxd, sh_q[6:1]};
          end
          if (n_q == (cfg.eight_bits ? 4'h7 : 4'h6)) begin
            st_d = (cfg.par_sel == uart_mode_pkg::par_none) ? sr_stop : sr_par;
          end
        end
        sr_par: if (os_q == uart_mode_pkg::os_last) begin
          st_d = sr_stop;
          // zero-parity scheme is never checked
          pe_d = (cfg.par_sel[1]) &&
                 (rxd != uart_mode_pkg::calc_par(sh_q, cfg.eight_bits, cfg.par_sel));
        end
        sr_stop: if (os_q == uart_mode_pkg::os_last) begin
          st_d = sr_idle; // one stop checked only
          fe_d = !rxd;
          dn_d = 1'b1;
          if (cfg.par_sel == uart_mode_pkg::par_none || cfg.par_sel == uart_mode_pkg::par_zero)
          begin
            pe_d = 1'b0;
          end
        end
        default: st_d = sr_idle;
      endcase
    end
  end
  // registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= sr_idle;
      os_q <= 4'h0;
      n_q  <= 4'h0;
      sh_q <= 8'h00;
      pe_q <= 1'b0;
      fe_q <= 1'b0;
      dn_q <= 1'b0;
    end else begin
      st_q <= st_d;
      os_q <= os_d;
      n_q  <= n_d;
      sh_q <= sh_d;
      pe_q <= pe_d;
      fe_q <= fe_d;
      dn_q <= dn_d;
    end
  end
endmodule

// ==== verilog/uart_tx_engine.sv ====
// transmit shifter: start, data, optional parity, one or two stops
// assumes the core holds the config stable while busy
`timescale 1ns/100ps
module uart_tx_engine (
  input  wire logic aclk,    // system clock
  input  wire logic aresetn, // sync reset, active low
  uart_cfg_if.tx    cfg,     // config and load
  output logic      txd_q    // serial output, idle high
);
  typedef enum {st_idle, st_start, st_data, st_par, st_stop} tx_state_t;
  tx_state_t  st_q, st_d;     // state
  logic [3:0] os_q, os_d;     // oversample count
  logic [3:0] n_q, n_d;       // bit count
  logic [7:0] sh_q, sh_d;     // shifter
  logic       p_q, p_d;       // parity bit to send
  logic       o_d;            // next line level
  assign cfg.tx_busy = (st_q != st_idle);
  // next-state logic
  always_comb begin
    st_d = st_q;
    os_d = os_q;
    n_d  = n_q;
    sh_d = sh_q;
    p_d  = p_q;
    o_d  = txd_q;
    if (st_q == st_idle) begin
      o_d = 1'b1;
      if (cfg.tx_start && cfg.tx_en) begin // start bit first
        st_d = st_start;
        sh_d = cfg.tx_byte;
        p_d  = uart_mode_pkg::calc_par(cfg.tx_byte, cfg.eight_bits, cfg.par_sel);
        os_d = 4'h0;
        o_d  = 1'b0;
      end
    end else if (cfg.tick) begin
      os_d = os_q + 4'h1;
      if (os_q == uart_mode_pkg::os_last) begin
        case (st_q)
          st_start: begin
            st_d = st_data;
            n_d  = 4'h0;
            o_d  = sh_q[0];
          end
          st_data: begin
            sh_d = {1'b0, sh_q[7:1]};
            n_d  = n_q + 4'h1;
            if (n_q == (cfg.eight_bits ? 4'h7 : 4'h6)) begin // 7 or 8 data
              if (cfg.par_sel != uart_mode_pkg::par_none) begin
                st_d = st_par;
                o_d  = p_q;
              end else begin
                st_d = st_stop;
                n_d  = 4'h0;
                o_d  = 1'b1;
              end
            end else begin
              o_d = sh_q[1];
            end
          end
          st_par: begin
            st_d = st_stop;
            n_d  = 4'h0;
            o_d  = 1'b1;
          end
          st_stop: begin
            n_d = n_q + 4'h1;
            if (!cfg.two_stop || n_q != 4'h0) begin // one or two stops
              st_d = st_idle;
            end
          end
          default: st_d = st_idle;
        endcase
      end
    end
  end
  // registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q  <= st_idle;
      os_q  <= 4'h0;
      n_q   <= 4'h0;
      sh_q  <= 8'h00;
      p_q   <= 1'b0;
      txd_q <= 1'b1;
    end else begin
      st_q  <= st_d;
      os_q  <= os_d;
      n_q   <= n_d;
      sh_q  <= sh_d;
      p_q   <= p_d;
      txd_q <= o_d;
    end
  end
endmodule
